// ==== logic/twrp_pkg.sv ====
package twrp_pkg;
  // register file geometry
  localparam int          TWRP_NUM_REGS  = 21;      // pointer values 0..14h
  localparam logic [7:0]  TWRP_PTR_TOP   = 8'h14;   // highest register pointer
  localparam logic [7:0]  TWRP_REG_RESET = 8'h00;   // power-on register contents
  localparam logic [7:0]  TWRP_PTR_RESET = 8'h00;   // power-on base pointer
  // address byte layout: upper five bits fixed, two from select pins
  localparam logic [4:0]  TWRP_ADDR_FIXED = 5'h13;  // fixed high part of slave address
  localparam int          TWRP_BITS_BYTE  = 8;      // bits per byte on the data line
  localparam logic [3:0]  TWRP_ACK_SLOT   = 4'h8;   // bit index of acknowledge slot

  // synchronised and edge-detected line state
  typedef struct packed {
    logic scl_rise;   // clock line went high
    logic scl_fall;   // clock line went low
    logic start;      // falling data while clock high
    logic stop;       // rising data while clock high
    logic sda;        // settled data level
  } twrp_line_t;

  // protocol phases
  typedef enum logic [2:0] {
    TWRP_IDLE, TWRP_ADDR, TWRP_PTR, TWRP_WDATA, TWRP_RDATA, TWRP_IGNORE
  } twrp_state_t;
endpackage : twrp_pkg

// ==== logic/twrp_port.sv ====
// Notes on behaviour
// RQ1 - all bytes travel most significant bit first
// RQ2 - refused write byte leaves data released high
// RQ3 - master nack on read ends data, release
// RQ4 - first write byte sets base pointer
// RQ5 - each further write byte advances pointer
// RQ6 - pointer saturates at top value 14h
// RQ7 - pointer above 14h gets no acknowledge
// RQ8 - master writes pointer before reading
// RQ9 - read starts at last written pointer
// RQ10 - pointer advances after each read byte
// RQ11 - stop returns port to idle
// RQ12 - repeated start decodes fresh address
// RQ13 - start is data falling, clock high
// RQ14 - address byte is seven bits plus direction
// RQ15 - matching address acknowledged on ninth pulse
// RQ16 - write bytes acknowledged and stored
`timescale 1ns/10ps
`default_nettype none
module twrp_port
  import twrp_pkg::*;
(
  input  wire logic                    clock,               // system clock 100 MHz
  input  wire logic                    rst_n,               // async reset, active low
  input  wire logic                    clk_en,              // freezes all state when low
  input  wire logic [1:0]              address_select_pins, // low address bits strap
  input  wire logic                    scl_in,              // serial clock pin level
  input  wire logic                    sda_in,              // serial data pin level
  output logic                         sda_out,             // always low when driving
  output logic                         sda_oe,              // high while pulling data low
  output logic [TWRP_NUM_REGS*8-1:0]   reg_file             // all control registers
);
  // two-stage synchronisers plus one history stage
  logic [2:0] scl_sync;   // [0] first stage, read only by [1]
  logic [2:0] sda_sync;   // same structure for data
  twrp_line_t line;       // decoded line events

  // synchroniser shift, no other logic on stage 0
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else if (clk_en) begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  // edge and condition decode from settled stages
  always_comb begin
    line.scl_rise = scl_sync[1] & ~scl_sync[2];
    line.scl_fall = ~scl_sync[1] & scl_sync[2];
    // RQ13 start detect
    line.start    = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
    // RQ11 stop detect
    line.stop     = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
    line.sda      = sda_sync[1];
  end

  // protocol state
  twrp_state_t state,    next_state;     // current phase
  logic [3:0]  bit_cnt,  next_bit_cnt;   // 0..7 data bits, 8 ack slot, 9 after master ack on read
  logic [7:0]  shreg,    next_shreg;     // shifts in write bytes, holds the byte being read
  logic [7:0]  ptr,      next_ptr;       // base register pointer
  logic        is_read,  next_is_read;   // direction of current byte phase
  logic        ack_ok,   next_ack_ok;    // this byte will be acknowledged
  logic        oe,       next_oe;        // data line pull-down
  logic [7:0]  regs      [TWRP_NUM_REGS];
  logic [7:0]  next_regs [TWRP_NUM_REGS];
  logic [6:0]  my_addr;                  // own slave address

  assign my_addr = {TWRP_ADDR_FIXED, address_select_pins};

  // byte at the current pointer, source for every read load
  logic [7:0]  rd_data;
  assign rd_data = reg_rd(ptr, regs);

  // saturating pointer step
  function automatic logic [7:0] ptr_step(input logic [7:0] p);
    // RQ6 saturate at top
    ptr_step = (p >= TWRP_PTR_TOP) ? TWRP_PTR_TOP : p + 8'h01;
  endfunction : ptr_step

  // register read with out-of-range guard
  function automatic logic [7:0] reg_rd(input logic [7:0] p, input logic [7:0] r [TWRP_NUM_REGS]);
    reg_rd = (p <= TWRP_PTR_TOP) ? r[p[4:0]] : 8'h00;
  endfunction : reg_rd

  // next-state computation
  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    next_ptr     = ptr;
    next_is_read = is_read;
    next_ack_ok  = ack_ok;
    next_oe      = oe;
    next_regs    = regs;
    if (line.stop) begin
      // RQ11 stop ends transfer
      next_state  = TWRP_IDLE;
      next_oe     = 1'b0;
      next_ack_ok = 1'b0;
    end else if (line.start) begin
      // RQ12 start or repeated start
      next_state   = TWRP_ADDR;
      next_bit_cnt = 4'h0;
      next_is_read = 1'b0;
      next_oe      = 1'b0;
      next_ack_ok  = 1'b0;
    end else if (state != TWRP_IDLE && state != TWRP_IGNORE) begin
      if (line.scl_rise) begin
        if (bit_cnt < TWRP_ACK_SLOT) begin
          // RQ1 shift in msb first
          if (!is_read) begin
            next_shreg = {shreg[6:0], line.sda};
          end
          next_bit_cnt = bit_cnt + 4'h1;
        end else if (is_read && bit_cnt == TWRP_ACK_SLOT) begin
          // RQ3 master nack ends data
          if (line.sda) begin
            next_state = TWRP_IGNORE;
          end else begin
            // master ack: next byte loads at this pulse's fall
            next_bit_cnt = TWRP_ACK_SLOT + 4'h1;
          end
        end
      end else if (line.scl_fall) begin
        if (state == TWRP_RDATA) begin
          if (bit_cnt == TWRP_ACK_SLOT) begin
            // RQ10 byte sent: release for master ack, step pointer
            next_oe  = 1'b0;
            next_ptr = ptr_step(ptr);
          end else if (bit_cnt > TWRP_ACK_SLOT) begin
            // master acked: drive msb of the byte at the new pointer
            next_shreg   = rd_data;
            next_oe      = ~rd_data[TWRP_BITS_BYTE-1];
            next_bit_cnt = 4'h0;
          end else begin
            // RQ1 drive next bit msb first
            next_oe = ~shreg[3'(TWRP_BITS_BYTE - 1) - bit_cnt[2:0]];
          end
        end else if (bit_cnt == TWRP_ACK_SLOT && !ack_ok) begin
          // byte complete: decide acknowledge and act
          next_ack_ok = 1'b0;
          unique case (state)
            TWRP_ADDR: begin
              // RQ14 seven bits plus direction, RQ15 match
              if (shreg[7:1] == my_addr) begin
                next_ack_ok = 1'b1;
              end
            end
            TWRP_PTR: begin
              // RQ7 refuse pointer above top, RQ4 store base
              if (shreg <= TWRP_PTR_TOP) begin
                next_ack_ok = 1'b1;
                next_ptr    = shreg;
              end
            end
            TWRP_WDATA: begin
              // RQ16 store and acknowledge write byte
              next_ack_ok = 1'b1;
              next_regs[ptr[4:0]] = shreg;
            end
            default: begin
              next_ack_ok = 1'b0;
            end
          endcase
          // RQ2 refusal keeps data released
          next_oe = next_ack_ok;
          if (!next_oe) begin
            next_state = TWRP_IGNORE;
          end
        end else if (bit_cnt == TWRP_ACK_SLOT) begin
          // end of ack slot: start next byte
          next_bit_cnt = 4'h0;
          next_oe      = 1'b0;
          next_ack_ok  = 1'b0;
          unique case (state)
            TWRP_ADDR: begin
              next_is_read = shreg[0];
              next_state   = shreg[0] ? TWRP_RDATA : TWRP_PTR;
              if (shreg[0]) begin
                // RQ9 first read byte from stored pointer
                next_shreg = rd_data;
                next_oe    = ~rd_data[TWRP_BITS_BYTE-1];
              end
            end
            TWRP_PTR:   next_state = TWRP_WDATA;
            // RQ5 advance after stored byte
            TWRP_WDATA: next_ptr = ptr_step(ptr);
            default:    next_state = TWRP_IGNORE;
          endcase
        end
      end
    end
  end

  // register all protocol state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state   <= TWRP_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
      ptr     <= TWRP_PTR_RESET;
      is_read <= 1'b0;
      ack_ok  <= 1'b0;
      oe      <= 1'b0;
      for (int i = 0; i < TWRP_NUM_REGS; i++) begin
        regs[i] <= TWRP_REG_RESET;
      end
    end else if (clk_en) begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
      ptr     <= next_ptr;
      is_read <= next_is_read;
      ack_ok  <= next_ack_ok;
      oe      <= next_oe;
      regs    <= next_regs;
    end
  end

  // outputs from flip-flops, drive level tied low
  assign sda_oe  = oe;
  assign sda_out = 1'b0;
  always_comb begin
    for (int i = 0; i < TWRP_NUM_REGS; i++) begin
      reg_file[i*8 +: 8] = regs[i];
    end
  end

  // RQ6 pointer never beyond top
  a_ptr_top_limit: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
    $changed(ptr) && state != TWRP_PTR |-> ptr <= TWRP_PTR_TOP)
    else $error("pointer advanced beyond top register");
  // RQ11 stop returns to idle
  a_stop_idle: assert property (@(posedge clock) disable iff (!rst_n) // RQ11
    clk_en && line.stop |=> state == TWRP_IDLE && !oe)
    else $error("stop did not return port to idle");
  // RQ12 start restarts address phase
  a_start_addr: assert property (@(posedge clock) disable iff (!rst_n) // RQ12
    clk_en && line.start && !line.stop |=> state == TWRP_ADDR && bit_cnt == 4'h0)
    else $error("start did not begin address phase");
  // RQ7 pointer above top never acknowledged
  a_ptr_refuse: assert property (@(posedge clock) disable iff (!rst_n) // RQ7
    clk_en && state == TWRP_PTR && shreg > TWRP_PTR_TOP && line.scl_fall
    && bit_cnt == TWRP_ACK_SLOT && !oe |=> !oe && state == TWRP_IGNORE)
    else $error("pointer above top was acknowledged");
  // RQ2 ignore phase keeps line released
  a_ignore_release: assert property (@(posedge clock) disable iff (!rst_n) // RQ2
    state == TWRP_IGNORE && $past(state) == TWRP_IGNORE |-> !oe)
    else $error("data line driven after refusal");
  // RQ3 master nack on read ends data phase
  a_read_nack: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
    clk_en && state == TWRP_RDATA && bit_cnt == TWRP_ACK_SLOT && line.scl_rise
    && line.sda && !line.start && !line.stop |=> state == TWRP_IGNORE)
    else $error("read nack did not end data");
  // RQ3 line released for master ack slot
  a_read_release: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
    clk_en && state == TWRP_RDATA && bit_cnt == TWRP_ACK_SLOT && line.scl_fall |=> !oe)
    else $error("data line held in master ack slot");
  // RQ15 mismatched address never driven
  a_addr_mismatch: assert property (@(posedge clock) disable iff (!rst_n) // RQ15
    clk_en && state == TWRP_ADDR && bit_cnt == TWRP_ACK_SLOT && line.scl_fall && !oe
    && !line.start && !line.stop && shreg[7:1] != my_addr |=> !oe)
    else $error("foreign address acknowledged");
  // RQ16 write byte lands in register
  a_write_store: assert property (@(posedge clock) disable iff (!rst_n) // RQ16
    clk_en && state == TWRP_WDATA && bit_cnt == TWRP_ACK_SLOT && line.scl_fall && !oe
    && !line.start && !line.stop |=> regs[$past(ptr[4:0])] == $past(shreg) && oe)
    else $error("write byte not stored");
endmodule : twrp_port
`default_nettype wire

// ==== bench/twrp_master.sv ====
`timescale 1ns/10ps
`default_nettype none
// bus master model: drives the clock, pulls data low open-drain
module twrp_master (
  input  wire logic clock,    // bench clock, paces the bit slots
  input  wire logic sda_line, // resolved data wire
  output var logic  scl,      // serial clock, parked high between frames
  output var logic  m_oe      // high while pulling data low
);
  // released lines at time zero
  initial begin
    scl  = 1'b1;
    m_oe = 1'b0;
  end
  // wait whole system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // one slot of 16 clocks; 4 clocks setup and hold around edges
  // data moves only on low clock
  task automatic bit_io(input logic b, output logic s);
    tick(4);
    m_oe <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(8);
    s = sda_line;
    scl <= 1'b0;
  endtask : bit_io
  task automatic start();
    tick(4);
    m_oe <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    m_oe <= 1'b1;
    tick(8);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    tick(4);
    m_oe <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    m_oe <= 1'b0;
    tick(8);
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr_byte
  // nack on the last byte ends the read
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(nack, s);
  endtask : rd_byte
endmodule : twrp_master
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import twrp_pkg::*;
  typedef struct packed {
    logic [1:0] pins;
    logic [7:0] ptr;
    logic [7:0] data;
  } twrp_row_t;
  logic                       clock = 1'b0; // 100 MHz
  logic                       rst_n;        // async reset
  logic                       clk_en;       // held running
  logic [1:0]                 pins;         // address strap
  logic                       scl;          // master clock
  logic                       m_oe;         // master pull-down
  logic                       sda_out;      // device drive level
  logic                       sda_oe;       // device pull-down
  wire logic                  sda_line;     // pulled-up data wire
  wire logic [6:0]            me = {TWRP_ADDR_FIXED, pins};
  logic [TWRP_NUM_REGS*8-1:0] regs;         // register contents
  logic [TWRP_NUM_REGS*8-1:0] snap;         // copy before refusal
  logic [7:0]                 q[$];         // bytes read back
  logic                       ok;           // all acks seen
  logic                       a;            // one ack
  int                         fail_count = 0;
  int                         compares = 0;
  // one strap per row, every pin value
  twrp_row_t rows [4] = '{'{2'h0, 8'h00, 8'hA5}, '{2'h1, 8'h07, 8'h3C},
                          '{2'h2, 8'h13, 8'h81}, '{2'h3, 8'h14, 8'h5A}};
  logic [7:0] exp_rd [4] = '{8'h11, 8'h22, 8'h44, 8'h44};
  always #5 clock = ~clock;
  // pull-up wins unless someone pulls low
  assign sda_line = m_oe ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  twrp_port i_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .address_select_pins(pins), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_file(regs));
  twrp_master i_mst (.clock(clock), .sda_line(sda_line), .scl(scl), .m_oe(m_oe));
  // count and report one comparison
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // write frame: pointer first, then data bytes
  task automatic wframe(input logic [7:0] b[$], output logic all);
    logic ack;
    i_mst.start();
    i_mst.wr_byte({me, 1'b0}, all);
    foreach (b[i]) begin
      i_mst.wr_byte(b[i], ack);
      all = all & ack;
    end
    i_mst.stop();
  endtask : wframe
  // pointer write, repeated start, n reads, nack on the last
  task automatic rframe(input logic [7:0] ptr, input int n, output logic [7:0] rd[$]);
    logic       ack;
    logic [7:0] d;
    rd = {};
    i_mst.start();
    i_mst.wr_byte({me, 1'b0}, ack);
    i_mst.wr_byte(ptr, ack);
    i_mst.start();
    i_mst.wr_byte({me, 1'b1}, ack);
    check("read addr ack", {7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      i_mst.rd_byte(i == n - 1, d);
      rd.push_back(d);
    end
    i_mst.tick(6);
    check("release after nack", {7'h00, sda_oe}, 8'h00);
    i_mst.stop();
  endtask : rframe
  // hang guard, well beyond the expected run
  initial begin
    #500000;
    fail_count++;
    final_report();
  end
  initial begin
    rst_n  = 1'b0;
    clk_en = 1'b1;
    pins   = 2'h0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    check("reset regs", {7'h00, regs == '0}, 8'h01);
    check("reset oe", {7'h00, sda_oe}, 8'h00);
    check("drive level", {7'h00, sda_out}, 8'h00);
    $display("reset test done");
    // ordinary rows: write one byte, read it back
    foreach (rows[i]) begin
      pins <= rows[i].pins;
      wframe({rows[i].ptr, rows[i].data}, ok);
      check("write acks", {7'h00, ok}, 8'h01);
      check("reg write", regs[rows[i].ptr*8 +: 8], rows[i].data);
      rframe(rows[i].ptr, 1, q);
      check("read back", q[0], rows[i].data);
      $display("row %0d done", i);
    end
    // foreign address gets no acknowledge
    i_mst.start();
    i_mst.wr_byte({TWRP_ADDR_FIXED, ~pins, 1'b0}, a);
    check("foreign addr ack", {7'h00, a}, 8'h00);
    i_mst.stop();
    $display("address test done");
    // burst past the top register saturates there
    wframe({8'h12, 8'h11, 8'h22, 8'h33, 8'h44}, ok);
    check("burst acks", {7'h00, ok}, 8'h01);
    check("reg 12h", regs[8'h12*8 +: 8], 8'h11);
    check("reg 13h", regs[8'h13*8 +: 8], 8'h22);
    check("reg 14h", regs[8'h14*8 +: 8], 8'h44);
    rframe(8'h12, 4, q);
    foreach (exp_rd[i]) check("burst read", q[i], exp_rd[i]);
    $display("burst test done");
    // pointer above top is refused, data after it ignored
    snap = regs;
    i_mst.start();
    i_mst.wr_byte({me, 1'b0}, a);
    i_mst.wr_byte(8'h15, a);
    check("bad ptr ack", {7'h00, a}, 8'h00);
    i_mst.wr_byte(8'h99, a);
    check("ignored data ack", {7'h00, a}, 8'h00);
    i_mst.stop();
    check("regs kept", {7'h00, regs == snap}, 8'h01);
    $display("refusal test done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
